// ==== hdl/nrc_host.sv ====
// Host sequencer driving a NAND target on its asynchronous pins
// Overview of operation
// RL1: Reset opcode makes the target drop any sequence in progress and go idle.
// RL2: Reset may abort a busy read, program or erase; touched data is invalid.
// RL3: After reset the target's latched command is cleared.
// RL4: After reset page and cache registers of the target are invalid.
// RL5: After reset the target status byte reads E0h with write-protect high, else 60h.
// RL6: After the reset opcode ready/busy goes low for the reset busy time.
// RL7: Reset busy lasts at most 1ms.
// RL8: Reset must be the very first command sent after power-on.
// RL9: Read identification only when no die is busy.
// RL10: After 90h the target stays in identification mode until a new command.
// RL11: 90h with address 00h returns five identification bytes.
// RL12: 90h with address 20h returns the four-byte signature.
// RL13: Cache read while array busy only after page read or cache read.
// RL14: Cache program while array busy only after a cache program.
// RL15: Internal move source and destination stay in one plane.
// RL16: One-time-programmable commands only after set-features with that feature address; the host only records this in otp_r and refuses no command for it.
// RL17: One-time-programmable read is 00h, five addresses, 30h, never while busy.
// RL18: Reset busy is visible on ready/busy and in the 70h status byte.
// RL19: The asynchronous interface is active from power-up.
// RL20: A command is opcode, address cycles, data cycles, optional confirm opcode.
// RL21: Identification addresses other than 00h or 20h give undefined data.
`timescale 1ns/1ps
`include "nrc_cfg.svh"
module nrc_host
    import nrc_pkg::*;
#(
    parameter int BUSY_TMO_CYC = `NRC_RST_CYC
) (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wr_data,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output      logic [31:0] rd_data,
    output      nrc_pins_t   pins,
    input  wire logic [7:0]  io_in,
    input  wire logic        rb_n
);
    localparam logic [19:0] STRB   = 20'(`NRC_STRB_CYC);
    localparam logic [19:0] WR_LEN = 20'(2 * `NRC_STRB_CYC);
    localparam logic [19:0] RD_LOW = 20'(2 * `NRC_STRB_CYC + `NRC_SYNC_CYC);
    localparam logic [19:0] RD_LEN = 20'(3 * `NRC_STRB_CYC + `NRC_SYNC_CYC);
    localparam logic [19:0] WB_LEN = 20'(`NRC_WB_CYC);
    localparam logic [19:0] TMO    = 20'(BUSY_TMO_CYC);

    function automatic logic is_cache_rd(input nrc_cmd_t c);
        is_cache_rd = (c.cmd1 == `NRC_OP_CACHE_SEQ && !c.has2) || c.cmd1 == `NRC_OP_CACHE_END
                      || (c.cmd1 == `NRC_OP_READ && c.has2
                          && (c.cmd2 == `NRC_OP_CACHE_SEQ || c.cmd2 == `NRC_OP_CACHE_RND));
    endfunction

    function automatic logic is_cache_pg(input nrc_cmd_t c);
        is_cache_pg = c.cmd1 == `NRC_OP_PROG && c.has2 && c.cmd2 == `NRC_OP_CACHE_PG;
    endfunction

    function automatic nrc_state_t st_after(input nrc_cmd_t c, input logic [1:0] lvl);
        st_after = ST_WAITB;
        if (c.has2)
            st_after = ST_CMD2;
        if (lvl < 2'h2 && c.wr && c.nbyte != 3'h0)
            st_after = ST_WDAT;
        if (lvl < 2'h1 && c.naddr != 3'h0)
            st_after = ST_ADDR;
    endfunction

    function automatic logic [2:0] clamp(input logic [2:0] n);
        clamp = (n > `NRC_MAX_BYTES) ? `NRC_MAX_BYTES : n;
    endfunction

    nrc_state_t  st_r;
    nrc_cmd_t    cmd_r;
    nrc_cmd_t    go_cmd;
    nrc_pins_t   pins_nxt;
    logic [19:0] cnt_r;
    logic [2:0]  idx_r;
    logic [39:0] addr_r;
    logic [39:0] move_addr_r;
    logic [31:0] wdata_r;
    logic [39:0] rdata_r;
    logic [31:0] rd_data_r;
    logic [2:0]  rb_s_r;
    logic [7:0]  io_s1_r;
    logic [7:0]  io_s2_r;
    logic [7:0]  io_s3_r;
    logic        rb_ready_r;
    logic        wp_hi_r;
    logic        rst_done_r;
    logic        refused_r;
    logic        tmo_r;
    logic        otp_r;
    logic        arr_busy_r;
    logic        prev_rd_r;
    logic        prev_cp_r;
    logic        move_ok_r;
    logic        go;
    logic        refuse_now;
    logic        go_ok;
    logic        byte_end;
    logic        stall;
    logic        wb_ok;
    logic        fin;
    logic        tmo_hit;

    // Pins from the far side settle over three stages; a change counts once two agree
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            rb_s_r     <= 3'h0;
            rb_ready_r <= 1'b0;
            io_s1_r    <= 8'h00;
            io_s2_r    <= 8'h00;
            io_s3_r    <= 8'h00;
        end
        else
        begin
            rb_s_r  <= {rb_s_r[1:0], rb_n};
            io_s1_r <= io_in;
            io_s2_r <= io_s1_r;
            io_s3_r <= io_s2_r;
            if (rb_s_r[2] == rb_s_r[1])
                rb_ready_r <= rb_s_r[2]; // RL6 RL18
        end
    end

    assign go = wr_en && addr == `NRC_REG_CTRL && wr_data[`NRC_CTRL_GO_BIT];

    always_comb
    begin
        go_cmd = nrc_cmd_t'(wr_data[23:0]);
        go_cmd.naddr = clamp(go_cmd.naddr);
        go_cmd.nbyte = clamp(go_cmd.nbyte);
        if (go_cmd.cmd1 == `NRC_OP_READ_ID)
        begin
            go_cmd.naddr = 3'h1; // RL10
            go_cmd.wr    = 1'b0;
            go_cmd.has2  = 1'b0;
            if (addr_r[7:0] == `NRC_ID_ADDR_MAKER)
                go_cmd.nbyte = `NRC_ID_LEN_MAKER; // RL11
            else if (addr_r[7:0] == `NRC_ID_ADDR_ONFI)
                go_cmd.nbyte = `NRC_ID_LEN_ONFI; // RL12
        end
    end

    always_comb
    begin
        refuse_now = 1'b0;
        if (!rst_done_r && go_cmd.cmd1 != `NRC_OP_RESET)
            refuse_now = 1'b1; // RL8
        if (!rb_ready_r && go_cmd.cmd1 != `NRC_OP_RESET && go_cmd.cmd1 != `NRC_OP_STATUS
            && go_cmd.cmd1 != `NRC_OP_STAT_ENH)
            refuse_now = 1'b1; // RL9 RL17
        if (arr_busy_r && is_cache_rd(go_cmd) && !prev_rd_r)
            refuse_now = 1'b1; // RL13
        if (arr_busy_r && is_cache_pg(go_cmd) && !prev_cp_r)
            refuse_now = 1'b1; // RL14
        if (go_cmd.cmd1 == `NRC_OP_MOVE_PG && go_cmd.has2 && move_ok_r
            && ((addr_r ^ move_addr_r) & `NRC_PLANE_MASK) != 40'h0)
            refuse_now = 1'b1; // RL15
    end

    assign go_ok    = go && st_r == ST_IDLE && !refuse_now;
    assign byte_end = (st_r == ST_RDAT) ? cnt_r == RD_LEN - 20'h1 : cnt_r == WR_LEN - 20'h1;
    assign stall    = st_r == ST_RDAT && cnt_r == RD_LOW - 20'h1 && io_s2_r != io_s3_r;
    assign wb_ok    = cnt_r >= WB_LEN - 20'h1 && rb_ready_r;
    assign tmo_hit  = st_r == ST_WAITB && !wb_ok && cnt_r >= TMO;
    assign fin      = (st_r == ST_WAITB && wb_ok && (cmd_r.wr || cmd_r.nbyte == 3'h0))
                      || (st_r == ST_RDAT && byte_end && idx_r == cmd_r.nbyte - 3'h1);

    // Opcode, address, data, confirm, then wait out busy and read back
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            st_r  <= ST_IDLE;
            cnt_r <= 20'h0;
            idx_r <= 3'h0;
        end
        else
        begin
            unique case (st_r)
                ST_IDLE:
                begin
                    cnt_r <= 20'h0;
                    idx_r <= 3'h0;
                    if (go_ok)
                        st_r <= ST_CMD1; // RL20
                end
                ST_CMD1, ST_CMD2:
                begin
                    cnt_r <= byte_end ? 20'h0 : cnt_r + 20'h1;
                    if (byte_end)
                        st_r <= (st_r == ST_CMD1) ? st_after(cmd_r, 2'h0) : ST_WAITB; // RL20
                end
                ST_ADDR, ST_WDAT, ST_RDAT:
                begin
                    if (!stall)
                        cnt_r <= byte_end ? 20'h0 : cnt_r + 20'h1;
                    if (byte_end)
                    begin
                        idx_r <= idx_r + 3'h1;
                        if (st_r == ST_ADDR && idx_r == cmd_r.naddr - 3'h1)
                        begin
                            idx_r <= 3'h0;
                            st_r  <= st_after(cmd_r, 2'h1);
                        end
                        if (st_r == ST_WDAT && idx_r == cmd_r.nbyte - 3'h1)
                        begin
                            idx_r <= 3'h0;
                            st_r  <= st_after(cmd_r, 2'h2);
                        end
                        if (fin)
                            st_r <= ST_IDLE;
                    end
                end
                ST_WAITB:
                begin
                    cnt_r <= cnt_r + 20'h1;
                    if (wb_ok)
                    begin
                        cnt_r <= 20'h0;
                        st_r  <= fin ? ST_IDLE : ST_RDAT; // RL6 RL7
                    end
                    else if (tmo_hit)
                        st_r <= ST_IDLE; // RL7
                end
                default:
                    st_r <= ST_IDLE;
            endcase
        end
    end

    // Strobe low for the first part of each byte, data held across the whole byte
    always_comb
    begin
        pins_nxt        = '0;
        pins_nxt.ce_n   = st_r == ST_IDLE;
        pins_nxt.we_n   = 1'b1;
        pins_nxt.re_n   = 1'b1;
        pins_nxt.wp_n   = wp_hi_r; // RL5
        unique case (st_r)
            ST_CMD1, ST_CMD2:
            begin
                pins_nxt.cle    = 1'b1;
                pins_nxt.io_oe  = 1'b1;
                pins_nxt.io_out = (st_r == ST_CMD1) ? cmd_r.cmd1 : cmd_r.cmd2;
                pins_nxt.we_n   = cnt_r >= STRB;
            end
            ST_ADDR:
            begin
                pins_nxt.ale    = 1'b1;
                pins_nxt.io_oe  = 1'b1;
                pins_nxt.io_out = addr_r[{idx_r, 3'h0} +: 8];
                pins_nxt.we_n   = cnt_r >= STRB;
            end
            ST_WDAT:
            begin
                pins_nxt.io_oe  = 1'b1;
                pins_nxt.io_out = idx_r[2] ? 8'h00 : wdata_r[{idx_r[1:0], 3'h0} +: 8];
                pins_nxt.we_n   = cnt_r >= STRB;
            end
            ST_RDAT:
                pins_nxt.re_n = cnt_r >= RD_LOW;
            default:
                pins_nxt.io_out = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            pins <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1, wp_n: 1'b0,
                      io_oe: 1'b0, io_out: 8'h00}; // RL19
        else
            pins <= pins_nxt;
    end

    // Software-written operands
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            cmd_r   <= '0;
            addr_r  <= 40'h0;
            wdata_r <= 32'h0;
            wp_hi_r <= 1'b0;
        end
        else
        begin
            if (go_ok)
                cmd_r <= go_cmd;
            if (wr_en && addr == `NRC_REG_ADDR_LO)
                addr_r[31:0] <= wr_data;
            if (wr_en && addr == `NRC_REG_ADDR_HI)
                addr_r[39:32] <= wr_data[7:0];
            if (wr_en && addr == `NRC_REG_WDATA)
                wdata_r <= wr_data;
            if (wr_en && addr == `NRC_REG_CFG)
                wp_hi_r <= wr_data[0];
        end
    end

    // Read bytes land at the point where the slow strobe has long settled
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            rdata_r <= 40'h0;
        else if (go_ok)
            rdata_r <= 40'h0;
        else if (st_r == ST_RDAT && cnt_r == RD_LOW - 20'h1 && !stall)
            rdata_r[{idx_r, 3'h0} +: 8] <= io_s3_r; // RL11 RL12 RL21
    end

    // Outcome flags; a refused order never disturbs the sequence in flight
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            refused_r <= 1'b0;
            tmo_r     <= 1'b0;
        end
        else
        begin
            if (go_ok)
            begin
                refused_r <= 1'b0;
                tmo_r     <= 1'b0;
            end
            if (go && !go_ok)
                refused_r <= 1'b1;
            if (tmo_hit)
                tmo_r <= 1'b1;
        end
    end

    // Command history that, except otp_r, gates later orders
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            rst_done_r  <= 1'b0;
            otp_r       <= 1'b0;
            arr_busy_r  <= 1'b0;
            prev_rd_r   <= 1'b0;
            prev_cp_r   <= 1'b0;
            move_ok_r   <= 1'b0;
            move_addr_r <= 40'h0;
        end
        else if (fin && cmd_r.cmd1 == `NRC_OP_RESET)
        begin
            rst_done_r <= 1'b1; // RL1 RL2 RL3 RL4
            otp_r      <= 1'b0;
            arr_busy_r <= 1'b0;
            prev_rd_r  <= 1'b0;
            prev_cp_r  <= 1'b0;
            move_ok_r  <= 1'b0;
        end
        else if (fin && cmd_r.cmd1 == `NRC_OP_STATUS)
        begin
            if (cmd_r.nbyte != 3'h0 && rdata_r[`NRC_ARRAY_READY_BIT])
                arr_busy_r <= 1'b0; // RL13 RL14
        end
        else if (fin && cmd_r.cmd1 != `NRC_OP_STAT_ENH)
        begin
            prev_rd_r  <= is_cache_rd(cmd_r)
                          || (cmd_r.cmd1 == `NRC_OP_READ && cmd_r.has2 && cmd_r.cmd2 == `NRC_OP_READ_GO);
            prev_cp_r  <= is_cache_pg(cmd_r);
            arr_busy_r <= is_cache_rd(cmd_r) || is_cache_pg(cmd_r);
            if (cmd_r.cmd1 == `NRC_OP_READ && cmd_r.has2 && cmd_r.cmd2 == `NRC_OP_MOVE_RD)
            begin
                move_ok_r   <= 1'b1; // RL15
                move_addr_r <= addr_r;
            end
            if (cmd_r.cmd1 == `NRC_OP_SET_FEAT && addr_r[7:0] == `NRC_OTP_FEAT)
                otp_r <= wdata_r[7:0] != 8'h00; // RL16
        end
    end

    // Read data appears in the cycle after the read strobe only
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            rd_data_r <= 32'h0;
        else if (!rd_en)
            rd_data_r <= 32'h0;
        else
        begin
            unique case (addr)
                `NRC_REG_CTRL:     rd_data_r <= {8'h00, cmd_r};
                `NRC_REG_ADDR_LO:  rd_data_r <= addr_r[31:0];
                `NRC_REG_ADDR_HI:  rd_data_r <= {24'h0, addr_r[39:32]};
                `NRC_REG_WDATA:    rd_data_r <= wdata_r;
                `NRC_REG_STATUS:   rd_data_r <= {22'h0, move_ok_r, prev_cp_r, prev_rd_r, arr_busy_r, otp_r,
                                                 tmo_r, refused_r, rst_done_r, rb_ready_r, st_r != ST_IDLE};
                `NRC_REG_RDATA_LO: rd_data_r <= rdata_r[31:0];
                `NRC_REG_RDATA_HI: rd_data_r <= {24'h0, rdata_r[39:32]};
                `NRC_REG_CFG:      rd_data_r <= {31'h0, wp_hi_r};
                default:           rd_data_r <= 32'h0;
            endcase
        end
    end

    assign rd_data = rd_data_r;
endmodule // nrc_host

// ==== hdl/nrc_cfg.svh ====
// Constants of the NAND reset / identify host controller
`ifndef NRC_CFG_SVH
`define NRC_CFG_SVH
`define NRC_CLK_MHZ      40
`define NRC_T_RST_US     1000
`define NRC_RST_CYC      (`NRC_T_RST_US * `NRC_CLK_MHZ)
`define NRC_T_STRB_NS    30
`define NRC_STRB_CYC     ((`NRC_T_STRB_NS * `NRC_CLK_MHZ + 999) / 1000)
`define NRC_T_WB_NS      100
`define NRC_WB_CYC       ((`NRC_T_WB_NS * `NRC_CLK_MHZ + 999) / 1000)
`define NRC_SYNC_CYC     3
`define NRC_MAX_BYTES    3'h5
`define NRC_REG_CTRL     8'h00
`define NRC_REG_ADDR_LO  8'h04
`define NRC_REG_ADDR_HI  8'h08
`define NRC_REG_WDATA    8'h0c
`define NRC_REG_STATUS   8'h10
`define NRC_REG_RDATA_LO 8'h14
`define NRC_REG_RDATA_HI 8'h18
`define NRC_REG_CFG      8'h1c
`define NRC_CTRL_GO_BIT  31
`define NRC_OP_RESET     8'hff
`define NRC_OP_READ_ID   8'h90
`define NRC_OP_STATUS    8'h70
`define NRC_OP_STAT_ENH  8'h78
`define NRC_OP_READ      8'h00
`define NRC_OP_READ_GO   8'h30
`define NRC_OP_CACHE_SEQ 8'h31
`define NRC_OP_CACHE_RND 8'h32
`define NRC_OP_CACHE_END 8'h3f
`define NRC_OP_PROG      8'h80
`define NRC_OP_CACHE_PG  8'h15
`define NRC_OP_PROG_GO   8'h10
`define NRC_OP_MOVE_RD   8'h35
`define NRC_OP_MOVE_PG   8'h85
`define NRC_OP_SET_FEAT  8'hef
`define NRC_ID_ADDR_MAKER 8'h00
`define NRC_ID_ADDR_ONFI 8'h20
`define NRC_ID_LEN_MAKER 3'h5
`define NRC_ID_LEN_ONFI  3'h4
`define NRC_OTP_FEAT     8'h90
`define NRC_ARRAY_READY_BIT     5
`define NRC_PLANE_MASK   40'h0000400000
`endif

// ==== hdl/nrc_pkg.sv ====
// Types of the NAND reset / identify host controller
package nrc_pkg;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_CMD1  = 3'h1,
        ST_ADDR  = 3'h3,
        ST_WDAT  = 3'h2,
        ST_CMD2  = 3'h6,
        ST_WAITB = 3'h7,
        ST_RDAT  = 3'h5
    } nrc_state_t;

    typedef struct packed {
        logic       ce_n;
        logic       cle;
        logic       ale;
        logic       we_n;
        logic       re_n;
        logic       wp_n;
        logic       io_oe;
        logic [7:0] io_out;
    } nrc_pins_t;

    typedef struct packed {
        logic [7:0] cmd1;
        logic [7:0] cmd2;
        logic [2:0] naddr;
        logic [2:0] nbyte;
        logic       has2;
        logic       wr;
    } nrc_cmd_t;
endpackage

// ==== tb/nrc_host_chk.sv ====
// Port assertions for the NAND host sequencer
`timescale 1ns/1ps
module nrc_host_chk
    import nrc_pkg::*;
#(
    parameter int BUSY_TMO_CYC = 40000
) (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic [7:0]  addr,
    input wire logic [31:0] wr_data,
    input wire logic        wr_en,
    input wire logic        rd_en,
    input wire logic [31:0] rd_data,
    input wire nrc_pins_t   pins,
    input wire logic [7:0]  io_in,
    input wire logic        rb_n
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    // Longest legal select: a timed-out reset plus the frame around it
    localparam int LOW_MAX = BUSY_TMO_CYC + 64;
    int   low_r;
    logic seen_r;
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            low_r  <= 0;
            seen_r <= 1'b0;
        end
        else
        begin
            low_r <= pins.ce_n ? 0 : low_r + 1;
            if ($rose(pins.we_n) && pins.cle)
                seen_r <= 1'b1;
        end
    end
    property p_rd_zero;
        !$past(rd_en) |-> rd_data == 32'h0;
    endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("read data outside read cycle");
    property p_go_lat;
        $fell(pins.ce_n) |-> $past(wr_en, 2) && $past(addr, 2) == 8'h00 && $past(wr_data[31], 2);
    endproperty
    a_go_lat: assert property (p_go_lat) else $error("select without start request");
    property p_we_pulse;
        $fell(pins.we_n) |-> ##1 !pins.we_n ##1 pins.we_n [*2];
    endproperty
    a_we_pulse: assert property (p_we_pulse) else $error("write strobe shape wrong");
    property p_latch_hold;
        $rose(pins.we_n) |-> $stable(pins.io_out) && $stable(pins.cle) && $stable(pins.ale) && pins.io_oe;
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("byte moved at latch edge");
    property p_idle_lvls;
        pins.ce_n |-> !pins.cle && !pins.ale && pins.we_n && pins.re_n && !pins.io_oe;
    endproperty
    a_idle_lvls: assert property (p_idle_lvls) else $error("pins not idle while deselected");
    property p_re_pulse;
        $fell(pins.re_n) |-> (!pins.re_n && !pins.io_oe) [*7];
    endproperty
    a_re_pulse: assert property (p_re_pulse) else $error("read strobe short or bus driven");
    property p_first_ff;
        $rose(pins.we_n) && pins.cle && !seen_r |-> pins.io_out == 8'hff;
    endproperty
    a_first_ff: assert property (p_first_ff) else $error("first opcode not reset");
    property p_busy_bound;
        low_r < LOW_MAX;
    endproperty
    a_busy_bound: assert property (p_busy_bound) else $error("select held too long");
endmodule // nrc_host_chk

bind nrc_host nrc_host_chk #(.BUSY_TMO_CYC(BUSY_TMO_CYC)) chk_i (.ref_clk(ref_clk), .rst(rst), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .pins(pins), .io_in(io_in), .rb_n(rb_n));

// ==== tb/nrc_nand_model.sv ====
// Behavioural NAND target driven by the host sequencer pins
`timescale 1ns/1ps
module nrc_nand_model
    import nrc_pkg::*;
#(
    parameter int         BUSY_RST_NS = 2000,
    parameter int         BUSY_OP_NS  = 300,
    parameter logic [7:0] MAKER_ID    = 8'h5a, // Arbitrary value
    parameter logic [7:0] PART_ID     = 8'h3c  // Arbitrary value
) (
    input  wire nrc_pins_t  pins,
    output      logic [7:0] io_in,
    output      logic       rb_n
);
    logic [7:0] cmd_r    = 8'h00;
    logic [7:0] id_adr_r = 8'h00;
    logic [7:0] stat_r   = 8'he0;
    logic [2:0] ptr_r    = 3'h0;
    logic       valid_r  = 1'b0;
    initial io_in = 8'h00;
    initial rb_n = 1'b1;
    function automatic logic [7:0] out_byte(input logic [2:0] i);
        if (cmd_r == 8'h70)
            return {stat_r[7], rb_n, stat_r[5] & rb_n, stat_r[4:0]};
        if (cmd_r != 8'h90)
            return ~io_in;
        if (id_adr_r == 8'h00)
            return (i == 0) ? MAKER_ID : (i == 1) ? PART_ID : (i == 2) ? 8'h80 : (i == 3) ? 8'h26 : 8'h62;
        if (id_adr_r == 8'h20 && i < 4)
            return (i == 0) ? 8'h4f : (i == 1) ? 8'h4e : (i == 2) ? 8'h46 : 8'h49;
        return {5'h15, i} ^ io_in;
    endfunction
    // Busy time is shortened; a real target may take up to 1 ms here
    always @(posedge pins.we_n)
    begin
        if (!pins.ce_n && pins.cle && pins.io_out == 8'hff)
        begin
            cmd_r = 8'hff;
            valid_r = 1'b0;
            stat_r = pins.wp_n ? 8'he0 : 8'h60;
            rb_n = 1'b0;
            rb_n <= #(BUSY_RST_NS) 1'b1;
        end
        else if (!pins.ce_n && pins.cle && (rb_n || pins.io_out == 8'h70))
        begin
            cmd_r = pins.io_out;
            ptr_r = 3'h0;
            if (pins.io_out inside {8'h30, 8'h31, 8'h32, 8'h35, 8'h3f, 8'h10, 8'h15})
            begin
                rb_n = 1'b0;
                rb_n <= #(BUSY_OP_NS) 1'b1;
            end
        end
        else if (!pins.ce_n && pins.ale && cmd_r == 8'h90)
            id_adr_r = pins.io_out;
    end
    always @(negedge pins.re_n)
    begin
        if (!pins.ce_n)
        begin
            io_in = out_byte(ptr_r);
            ptr_r = ptr_r + 3'h1;
        end
    end
    // Released bus flips so a stale byte never passes for data
    always @(posedge pins.re_n or posedge pins.ce_n)
        io_in = ~io_in;
endmodule // nrc_nand_model

// ==== tb/nrc_host_bench.sv ====
// Self-checking bench for the NAND host sequencer
`timescale 1ns/1ps
module nrc_host_bench;
    import nrc_pkg::*;
    localparam logic [7:0] MAKER = 8'h5a; // Arbitrary value
    localparam logic [7:0] PART  = 8'h3c; // Arbitrary value
    logic        ref_clk = 1'b0;
    logic        rst     = 1'b1;
    logic [7:0]  addr    = 8'h00;
    logic [31:0] wr_data = 32'h0;
    logic        wr_en   = 1'b0;
    logic        rd_en   = 1'b0;
    logic [31:0] rd_data;
    nrc_pins_t   pins;
    logic [7:0]  io_in;
    logic        rb_n;
    logic [31:0] v;
    int          fails   = 0;
    int          checks  = 0;
    logic [31:0] t_adr [13] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 32'h400000, 0, 32'h90, 0};
    // Control word: [23:16] first opcode, [15:8] confirm, [7:5] addresses, [4:2] bytes, [1] confirm, [0] write
    logic [31:0] t_ctl [13] = '{32'h80310000, 32'h808015a7, 32'h80310000, 32'h80700004, 32'h808015a7,
        32'h80310000, 32'h808015a7, 32'h80ff0000, 32'h800035a2, 32'h808510a3, 32'h808510a3,
        32'h80ef0031, 32'h800030a2};
    logic [9:0]  t_msk [13] = '{'h48, 'h48, 'h8, 'h48, 'h48, 'h8, 'h8, 'h48, 'h8, 'h8, 'h8, 'h28, 'h8};
    logic [9:0]  t_exp [13] = '{'h40, 'h48, 'h0, 'h0, 'h40, 'h8, 'h0, 'h0, 'h0, 'h8, 'h0, 'h20, 'h0};
    always #12.5 ref_clk = ~ref_clk;
    nrc_host #(.BUSY_TMO_CYC(200)) uut (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .pins(pins), .io_in(io_in), .rb_n(rb_n));
    nrc_nand_model #(.MAKER_ID(MAKER), .PART_ID(PART)) nand_i (.pins(pins), .io_in(io_in), .rb_n(rb_n));
    task automatic wrap_up();
        $display("Checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        checks++;
        if (s !== e)
        begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge ref_clk);
        wr_en   <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1;
        d = rd_data;
    endtask
    // Start a command, then poll status until the sequencer is idle
    task automatic go(input logic [31:0] c);
        int n;
        n = 0;
        wr(8'h00, c);
        do
        begin
            rd(8'h10, v);
            n++;
        end
        while (v[0] !== 1'b0 && n < 400);
        if (n >= 400)
        begin
            fails++;
            $display("Error wait_idle expected 0 seen 1");
            wrap_up();
        end
    endtask
    initial
    begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        #1;
        chk("reset pins", 32'h4c00, 32'(pins));
        go(32'h80900034);
        chk("early refusal", 32'h8, v & 32'hc);
        for (int i = 0; i < 2; i++)
        begin
            wr(8'h1c, 32'(i));
            go(32'h80ff0000);
            chk("reset status", 32'h6, v & 32'hf);
            go(32'h80700004);
            rd(8'h14, v);
            chk("status byte", i ? 32'he0 : 32'h60, v & 32'hff);
        end
        wr(8'h04, 32'h0);
        go(32'h80900034);
        rd(8'h14, v);
        chk("id low", {8'h26, 8'h80, PART, MAKER}, v);
        rd(8'h18, v);
        chk("id high", 32'h62, v & 32'hff);
        wr(8'h04, 32'h20);
        go(32'h80900030);
        rd(8'h14, v);
        chk("id signature", 32'h49464e4f, v);
        // Feature value must be non-zero for the one-time-programmable entry to count
        wr(8'h0c, 32'h1);
        for (int i = 0; i < 13; i++)
        begin
            wr(8'h04, t_adr[i]);
            go(t_ctl[i]);
            chk("status flags", 32'(t_exp[i]), v & 32'(t_msk[i]));
        end
        wrap_up();
    end
endmodule // nrc_host_bench
